// ---- i2c_host.sv ----
// Purpose: bus master for a two-core sensor, accelerometer and magnetometer
// Assumes: open-drain lines with pull-ups, one outstanding command
// Notes:   serial clock is divided from ref_clk_i, no second domain
`timescale 1ns/1ns

module i2c_host
#(
    parameter int unsigned QTR = i2c_host_pkg::QTR_CYC
)
(
    input  wire logic       ref_clk_i,
    input  wire logic       srst_i,
    input  wire logic       ce_i,
    input  wire logic       cmd_valid_i,
    output logic            cmd_ready_o,
    input  wire logic       cmd_mag_i,
    input  wire logic       cmd_read_i,
    input  wire logic [6:0] cmd_reg_i,
    input  wire logic [7:0] cmd_len_i,
    input  wire logic       wr_valid_i,
    input  wire logic [7:0] wr_data_i,
    output logic            wr_ready_o,
    output logic            rd_valid_o,
    output logic [7:0]      rd_data_o,
    output logic            rd_last_o,
    output logic            done_o,
    output logic            nack_o,
    output logic            busy_o,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o
);
    i2c_host_pkg::state_t state_r;
    logic [1:0]           qtr_r;
    logic [3:0]           bit_idx_r;
    logic [7:0]           shift_r;
    logic [7:0]           cnt_r;
    logic                 mag_r;
    logic                 read_r;
    logic [6:0]           reg_r;
    logic                 ack_r;
    logic                 sda_d_r;
    logic                 tick;
    logic                 run;
    logic                 take;
    logic                 byte_st;
    logic                 rx_st;
    logic                 bit_val;
    logic                 wait_wr;
    logic [6:0]           dev_addr;
    logic [7:0]           sub_byte;

    pins_if pins ();

    // ****************************************
    // line synchronisers and bit timing
    // ****************************************
    pin_sync u_sync
    (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .pins      (pins.src)
    );

    qtr_tick #(.QTR(QTR)) u_tick
    (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .run_i     (run),
        .tick_o    (tick)
    );

    // ****************************************
    // decode of the current slot
    // ****************************************
    assign take    = cmd_valid_i && cmd_ready_o;
    assign rx_st   = (state_r == i2c_host_pkg::ST_RDATA);
    assign byte_st = (state_r == i2c_host_pkg::ST_ADDR) ||
                     (state_r == i2c_host_pkg::ST_SUB) ||
                     (state_r == i2c_host_pkg::ST_WDATA) ||
                     (state_r == i2c_host_pkg::ST_RADDR) || rx_st;
    // write byte not yet offered: hold clock low until it is
    assign wait_wr = (state_r == i2c_host_pkg::ST_WDATA) && (qtr_r == 2'h0) &&
                     (bit_idx_r == 4'h0) && !wr_valid_i;
    // quarter 2 starts only once the clock is seen high
    assign run     = (state_r != i2c_host_pkg::ST_IDLE) &&
                     !((qtr_r == 2'h2) && !pins.scl_s);
    assign dev_addr = mag_r ? i2c_host_pkg::MAG_ADDR
                            : i2c_host_pkg::ACC_ADDR;
    // pointer byte goes out as given for the magnetometer
    assign sub_byte = mag_r ? {1'h0, reg_r}
                            : {(cnt_r != 8'h00) && i2c_host_pkg::AUTOINC_ON, reg_r};

    always_comb
    begin
        bit_val = 1'h1;
        if (bit_idx_r == i2c_host_pkg::ACK_SLOT)
        begin
            // own ack only in the read phase; nack on the last byte
            bit_val = rx_st ? (cnt_r == 8'h00) : 1'h1;
        end
        else if (!rx_st)
        begin
            bit_val = shift_r[7];
        end
    end

    // ****************************************
    // command port
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            cmd_ready_o <= 1'h0;
        end
        else if (ce_i)
        begin
            // a foreign master owning the bus blocks new work
            cmd_ready_o <= (state_r == i2c_host_pkg::ST_IDLE) && !busy_o && !take;
        end
    end

    // ****************************************
    // bus monitor
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            sda_d_r <= 1'h1;
            busy_o  <= 1'h0;
        end
        else if (ce_i)
        begin
            sda_d_r <= pins.sda_s;
            if (pins.scl_s && sda_d_r && !pins.sda_s)
            begin
                busy_o <= 1'h1;
            end
            else if (pins.scl_s && !sda_d_r && pins.sda_s)
            begin
                busy_o <= 1'h0;
            end
        end
    end

    // ****************************************
    // line drivers
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            scl_o    <= 1'h0;
            sda_o    <= 1'h0;
            scl_oe_o <= 1'h0;
            sda_oe_o <= 1'h0;
        end
        else if (ce_i && tick && !wait_wr)
        begin
            case (qtr_r)
                2'h0:
                begin
                    if (state_r == i2c_host_pkg::ST_START || state_r == i2c_host_pkg::ST_RSTART)
                    begin
                        sda_oe_o <= 1'h0;
                    end
                    else if (state_r == i2c_host_pkg::ST_STOP)
                    begin
                        sda_oe_o <= 1'h1;
                    end
                    else if (state_r == i2c_host_pkg::ST_WDATA && bit_idx_r == 4'h0)
                    begin
                        sda_oe_o <= !wr_data_i[7];
                    end
                    else
                    begin
                        sda_oe_o <= !bit_val;
                    end
                end
                2'h1:
                begin
                    scl_oe_o <= 1'h0;
                end
                2'h2:
                begin
                    if (state_r == i2c_host_pkg::ST_START || state_r == i2c_host_pkg::ST_RSTART)
                    begin
                        sda_oe_o <= 1'h1;
                    end
                end
                default:
                begin
                    if (state_r == i2c_host_pkg::ST_STOP)
                    begin
                        sda_oe_o <= 1'h0;
                    end
                    else
                    begin
                        scl_oe_o <= 1'h1;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            state_r    <= i2c_host_pkg::ST_IDLE;
            qtr_r      <= 2'h0;
            bit_idx_r  <= 4'h0;
            shift_r    <= 8'h00;
            cnt_r      <= 8'h00;
            mag_r      <= 1'h0;
            read_r     <= 1'h0;
            reg_r      <= 7'h00;
            ack_r      <= 1'h0;
            wr_ready_o <= 1'h0;
            rd_valid_o <= 1'h0;
            rd_data_o  <= 8'h00;
            rd_last_o  <= 1'h0;
            done_o     <= 1'h0;
            nack_o     <= 1'h0;
        end
        else if (ce_i)
        begin
            wr_ready_o <= 1'h0;
            rd_valid_o <= 1'h0;
            rd_last_o  <= 1'h0;
            done_o     <= 1'h0;
            nack_o     <= 1'h0;
            if (take)
            begin
                state_r   <= i2c_host_pkg::ST_START;
                qtr_r     <= 2'h0;
                bit_idx_r <= 4'h0;
                mag_r     <= cmd_mag_i;
                read_r    <= cmd_read_i;
                reg_r     <= cmd_reg_i;
                cnt_r     <= cmd_len_i;
                ack_r     <= 1'h1;
            end
            else if (tick && !wait_wr && state_r != i2c_host_pkg::ST_IDLE)
            begin
                qtr_r <= qtr_r + 2'h1;
                if (qtr_r == 2'h0 && state_r == i2c_host_pkg::ST_WDATA && bit_idx_r == 4'h0)
                begin
                    shift_r    <= wr_data_i;
                    wr_ready_o <= 1'h1;
                end
                if (qtr_r == 2'h2 && byte_st)
                begin
                    if (bit_idx_r == i2c_host_pkg::ACK_SLOT)
                    begin
                        ack_r <= rx_st ? ack_r : !pins.sda_s;
                    end
                    else
                    begin
                        shift_r <= {shift_r[6:0], pins.sda_s};
                    end
                end
                if (qtr_r == i2c_host_pkg::QTR_LAST)
                begin
                    if (byte_st && bit_idx_r != i2c_host_pkg::ACK_SLOT)
                    begin
                        bit_idx_r <= bit_idx_r + 4'h1;
                    end
                    else
                    begin
                        bit_idx_r <= 4'h0;
                        case (state_r)
                            i2c_host_pkg::ST_START:
                            begin
                                shift_r <= {dev_addr, i2c_host_pkg::DIR_WR};
                                state_r <= i2c_host_pkg::ST_ADDR;
                            end
                            i2c_host_pkg::ST_ADDR:
                            begin
                                shift_r <= sub_byte;
                                state_r <= ack_r ? i2c_host_pkg::ST_SUB : i2c_host_pkg::ST_STOP;
                            end
                            i2c_host_pkg::ST_SUB:
                            begin
                                state_r <= !ack_r ? i2c_host_pkg::ST_STOP
                                         : read_r ? i2c_host_pkg::ST_RSTART : i2c_host_pkg::ST_WDATA;
                            end
                            i2c_host_pkg::ST_WDATA:
                            begin
                                cnt_r   <= cnt_r - 8'h01;
                                state_r <= (!ack_r || cnt_r == 8'h00) ? i2c_host_pkg::ST_STOP
                                                                      : i2c_host_pkg::ST_WDATA;
                            end
                            i2c_host_pkg::ST_RSTART:
                            begin
                                shift_r <= {dev_addr, i2c_host_pkg::DIR_RD};
                                state_r <= i2c_host_pkg::ST_RADDR;
                            end
                            i2c_host_pkg::ST_RADDR:
                            begin
                                state_r <= ack_r ? i2c_host_pkg::ST_RDATA
                                                 : i2c_host_pkg::ST_STOP;
                            end
                            i2c_host_pkg::ST_RDATA:
                            begin
                                rd_valid_o <= 1'h1;
                                rd_data_o  <= shift_r;
                                rd_last_o  <= (cnt_r == 8'h00);
                                cnt_r      <= cnt_r - 8'h01;
                                state_r    <= (cnt_r == 8'h00) ? i2c_host_pkg::ST_STOP
                                                               : i2c_host_pkg::ST_RDATA;
                            end
                            i2c_host_pkg::ST_STOP:
                            begin
                                // bus released, report outcome
                                state_r <= i2c_host_pkg::ST_IDLE;
                                done_o  <= 1'h1;
                                nack_o  <= !ack_r;
                            end
                            default:
                            begin
                                state_r <= i2c_host_pkg::ST_IDLE;
                            end
                        endcase
                    end
                end
            end
        end
    end
endmodule : i2c_host

// ---- i2c_host_monitor.sv ----
// Purpose: port assertions for the two-core sensor bus controller
// Assumes: one clock domain, ref_clk_i
// Notes:   bound to every i2c_host
`timescale 1ns/1ns
module i2c_host_monitor
(
    input wire logic       ref_clk_i,
    input wire logic       srst_i,
    input wire logic       cmd_valid_i,
    input wire logic       cmd_ready_o,
    input wire logic [7:0] wr_data_i,
    input wire logic       wr_ready_o,
    input wire logic       rd_valid_o,
    input wire logic       rd_last_o,
    input wire logic       done_o,
    input wire logic       nack_o,
    input wire logic       scl_o,
    input wire logic       scl_oe_o,
    input wire logic       sda_o,
    input wire logic       sda_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    // ****************************************
    // assertions
    // ****************************************
    drive_low_a: assert property (!scl_o && !sda_o) else $error("line driven high");
    take_drop_a: assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o) else $error("ready kept");
    nack_done_a: assert property (nack_o |-> done_o) else $error("nack without done");
    last_valid_a: assert property (rd_last_o |-> rd_valid_o) else $error("last without valid");
    rd_pulse_a: assert property (rd_valid_o |=> !rd_valid_o) else $error("read valid too long");
    done_once_a: assert property (done_o |=> !done_o) else $error("done too long");
    msb_first_a: assert property (wr_ready_o |-> sda_oe_o == !$past(wr_data_i[7])) else $error("bad first bit");
    clock_low_a: assert property (wr_ready_o |-> scl_oe_o) else $error("data set with clock high");
    stop_free_a: assert property (done_o |-> !scl_oe_o && !sda_oe_o) else $error("lines held at end");
    cover property (done_o && nack_o);
    cover property (rd_last_o);
    cover property (wr_ready_o);
endmodule : i2c_host_monitor

bind i2c_host i2c_host_monitor i_mon (.ref_clk_i, .srst_i, .cmd_valid_i, .cmd_ready_o, .wr_data_i, .wr_ready_o,
    .rd_valid_o, .rd_last_o, .done_o, .nack_o, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o);

// ---- i2c_host_pkg.sv ----
// Purpose: shared constants and types of the two-sensor bus controller
// Assumes: ref_clk_i at 125 MHz, controller owns the serial clock
// Notes:   none
package i2c_host_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_HZ  = 125_000_000;
    localparam int unsigned SCL_HZ  = 100_000;
    // shortest quarter period, rounded down
    localparam int unsigned QTR_CYC = CLK_HZ / (4 * SCL_HZ);

    // ****************************************
    // bus addresses and byte layout
    // ****************************************
    localparam logic [6:0] ACC_ADDR    = 7'h19;
    localparam logic [6:0] MAG_ADDR    = 7'h1e;
    localparam logic       DIR_RD      = 1'h1;
    localparam logic       DIR_WR      = 1'h0;
    localparam logic       AUTOINC_ON  = 1'h1;
    localparam logic [3:0] ACK_SLOT    = 4'h8;
    localparam logic [1:0] QTR_LAST    = 2'h3;

    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_START  = 4'b0001,
        ST_ADDR   = 4'b0010,
        ST_SUB    = 4'b0011,
        ST_WDATA  = 4'b0100,
        ST_RSTART = 4'b0101,
        ST_RADDR  = 4'b0110,
        ST_RDATA  = 4'b0111,
        ST_STOP   = 4'b1000
    } state_t;

endpackage : i2c_host_pkg

// ---- pin_sync.sv ----
// Purpose: two-flop synchroniser for the open-drain line inputs
// Assumes: lines are asynchronous to ref_clk_i
// Notes:   first stage is read only by the second
`timescale 1ns/1ns
module pin_sync
(
    input  wire logic       ref_clk_i,
    input  wire logic       srst_i,
    input  wire logic       ce_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    pins_if.src             pins
);
    logic [1:0] meta_r;
    logic [1:0] sync_r;
    logic [1:0] raw;

    assign raw = {scl_i, sda_i};

    // ****************************************
    // one synchroniser per line
    // ****************************************
    for (genvar i = 0; i < 2; i++)
    begin : g_sync
        always_ff @(posedge ref_clk_i)
        begin
            if (srst_i)
            begin
                // idle bus level is high
                meta_r[i] <= 1'h1;
                sync_r[i] <= 1'h1;
            end
            else if (ce_i)
            begin
                meta_r[i] <= raw[i];
                sync_r[i] <= meta_r[i];
            end
        end
    end

    assign pins.scl_s = sync_r[1];
    assign pins.sda_s = sync_r[0];
endmodule : pin_sync

// ---- pins_if.sv ----
// Purpose: synchronised line levels passed from the pin stage to the sequencer
// Assumes: both fields are in the ref_clk_i domain
// Notes:   none
`timescale 1ns/1ns
interface pins_if;
    logic scl_s;
    logic sda_s;

    modport src (output scl_s, output sda_s);
    modport snk (input scl_s, input sda_s);
endinterface : pins_if

// ---- qtr_tick.sv ----
// Purpose: quarter-bit tick for the serial clock
// Assumes: run_i low restarts the count
// Notes:   a stalled run gives a full quarter after release
`timescale 1ns/1ns
module qtr_tick
#(
    parameter int unsigned QTR = i2c_host_pkg::QTR_CYC
)
(
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    input  wire logic ce_i,
    input  wire logic run_i,
    output logic      tick_o
);
    localparam int unsigned CW = $clog2(QTR + 1);

    if (QTR < 2)
    begin : g_chk
        $error("qtr_tick: quarter period below two cycles");
    end

    logic [CW-1:0] cnt_r;

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            cnt_r  <= '0;
            tick_o <= 1'h0;
        end
        else if (ce_i)
        begin
            tick_o <= 1'h0;
            if (!run_i)
            begin
                cnt_r <= '0;
            end
            else if (cnt_r == CW'(QTR - 1))
            begin
                cnt_r  <= '0;
                tick_o <= 1'h1;
            end
            else
            begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule : qtr_tick

// ---- sensor_dev.sv ----
// Purpose: behavioural two-core sensor on the open-drain lines
// Assumes: lines resolved by the bench with pull-ups
// Notes:   stall_i stretches the clock after every acknowledged byte
`timescale 1ns/1ns
module sensor_dev
(
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic refuse_i,
    input  wire logic stall_i,
    output logic      scl_oe_o,
    output logic      sda_oe_o
);
    // ****************************************
    // byte engine, 0 idle 1 addr 2 sub 3 write 4 read
    // ****************************************
    logic [7:0] acc_mem [128];
    logic [7:0] mag_mem [13];
    logic [7:0] sh_r, tx_r;
    logic [6:0] ptr_r;
    logic       mag_r, ainc_r;
    int         st_r = 0;
    int         bit_r = 0;

    initial
    begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        for (int i = 0; i < 128; i++) acc_mem[i] = 8'(i) ^ 8'h5a;
        for (int i = 0; i < 13; i++) mag_mem[i] = 8'(i) + 8'h40;
    end

    function automatic void advance();
        if (mag_r)
            ptr_r = (ptr_r == 7'h08) ? 7'h03 : (ptr_r >= 7'h0c) ? 7'h00 : ptr_r + 7'h01;
        else if (ainc_r)
            ptr_r = ptr_r + 7'h01;
    endfunction : advance

    function automatic logic take_byte();
        take_byte = 1'b1;
        if (st_r == 1)
        begin
            mag_r = (sh_r[7:1] == 7'h1e);
            if (refuse_i || !(mag_r || sh_r[7:1] == 7'h19))
            begin
                st_r = 0;
                take_byte = 1'b0;
            end
            else
                st_r = sh_r[0] ? 4 : 2;
        end
        else if (st_r == 2)
        begin
            ptr_r = sh_r[6:0];
            ainc_r = sh_r[7];
            st_r = 3;
        end
        else
        begin
            if (!mag_r)
                acc_mem[ptr_r] = sh_r;
            else if (ptr_r <= 7'h0c)
                mag_mem[ptr_r] = sh_r;
            advance();
        end
    endfunction : take_byte

    always @(negedge sda_i)
        if (scl_i === 1'b1)
        begin
            st_r = 1;
            bit_r = -1;
        end

    always @(posedge sda_i)
        if (scl_i === 1'b1)
        begin
            st_r = 0;
            sda_oe_o = 1'b0;
        end

    always @(posedge scl_i)
        if (st_r != 0)
        begin
            if (bit_r < 8)
                sh_r = {sh_r[6:0], sda_i};
            else if (st_r == 4 && sda_i)
                st_r = 0;
        end

    always @(negedge scl_i)
        if (st_r != 0)
        begin
            bit_r = bit_r + 1;
            if (bit_r == 8)
                sda_oe_o = (st_r == 4) ? 1'b0 : take_byte();
            else if (bit_r == 9)
            begin
                bit_r = 0;
                sda_oe_o = 1'b0;
                if (st_r == 4)
                begin
                    // pointer itself never goes out, only the data it selects
                    tx_r = !mag_r ? acc_mem[ptr_r] : (ptr_r <= 7'h0c) ? mag_mem[ptr_r] : 8'h00;
                    advance();
                    sda_oe_o = !tx_r[7];
                end
                if (stall_i)
                begin
                    scl_oe_o = 1'b1;
                    #700;
                    scl_oe_o = 1'b0;
                end
            end
            else if (st_r == 4)
                sda_oe_o = !tx_r[7 - bit_r];
        end
endmodule : sensor_dev

// ---- tb.sv ----
// Purpose: self-checking bench for the sensor bus controller
// Assumes: short quarter period, so each accepted transfer takes about a thousand cycles
// Notes:   four transfers only, to keep the run short
`timescale 1ns/1ns
module tb;
    // ****************************************
    // bench
    // ****************************************
    logic       ref_clk_i = 1'b0;
    logic       srst_i = 1'b1;
    logic       cmd_valid_i = 1'b0, cmd_mag_i = 1'b0, cmd_read_i = 1'b0, wr_valid_i = 1'b0;
    logic [6:0] cmd_reg_i = 7'h00;
    logic [7:0] cmd_len_i = 8'h01, wr_data_i = 8'h00, rd_data_o;
    logic       cmd_ready_o, wr_ready_o, rd_valid_o, rd_last_o, done_o, nack_o, busy_o;
    logic       scl_o, scl_oe_o, sda_o, sda_oe_o, dev_scl_oe, dev_sda_oe;
    logic       refuse = 1'b0, stall = 1'b0, got_nack, got_last;
    logic [7:0] rd_q [$];
    int         n_mismatch = 0, n_compared = 0;
    wire        scl = !(scl_oe_o || dev_scl_oe);
    wire        sda = !(sda_oe_o || dev_sda_oe);

    i2c_host #(.QTR(4)) i_dut (.ref_clk_i, .srst_i, .ce_i(1'b1), .cmd_valid_i, .cmd_ready_o, .cmd_mag_i, .cmd_read_i,
        .cmd_reg_i, .cmd_len_i, .wr_valid_i, .wr_data_i, .wr_ready_o, .rd_valid_o, .rd_data_o, .rd_last_o,
        .done_o, .nack_o, .busy_o, .scl_i(scl), .scl_o, .scl_oe_o, .sda_i(sda), .sda_o, .sda_oe_o);
    sensor_dev i_dev (.scl_i(scl), .sda_i(sda), .refuse_i(refuse), .stall_i(stall), .scl_oe_o(dev_scl_oe),
        .sda_oe_o(dev_sda_oe));

    always #4 ref_clk_i = !ref_clk_i;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // two-byte command; write data d0 then d1
    task automatic run_cmd(input logic mag, input logic rd, input logic [6:0] rg, input logic [7:0] d0,
        input logic [7:0] d1);
        int n;
        rd_q = {};
        @(posedge ref_clk_i);
        cmd_mag_i <= mag;
        cmd_read_i <= rd;
        cmd_reg_i <= rg;
        cmd_valid_i <= 1'b1;
        wr_data_i <= d0;
        wr_valid_i <= !rd;
        for (n = 0; n < 20000; n++)
        begin
            @(posedge ref_clk_i);
            if (cmd_valid_i && cmd_ready_o === 1'b1)
                cmd_valid_i <= 1'b0;
            if (wr_ready_o === 1'b1)
                wr_data_i <= d1;
            if (wr_ready_o === 1'b1 || rd_valid_o === 1'b1)
                check("busy", {7'h00, busy_o}, 8'h01);
            if (rd_valid_o === 1'b1)
            begin
                rd_q.push_back(rd_data_o);
                got_last = rd_last_o;
            end
            if (done_o === 1'b1)
                break;
        end
        wr_valid_i <= 1'b0;
        got_nack = nack_o;
        if (n == 20000)
        begin
            n_mismatch++;
            $display("FAIL done expected 1 seen 0");
            give_verdict();
        end
    endtask : run_cmd

    task automatic test_acc_write();
        stall <= 1'b1;
        run_cmd(1'b0, 1'b0, 7'h20, 8'ha5, 8'h3c);
        check("acc reg 20", i_dev.acc_mem[32], 8'ha5);
        check("acc reg 21", i_dev.acc_mem[33], 8'h3c);
        check("write nack", {7'h00, got_nack}, 8'h00);
        run_cmd(1'b0, 1'b1, 7'h20, 8'h00, 8'h00);
        stall <= 1'b0;
        check("acc read 20", rd_q[0], 8'ha5);
        check("acc read 21", rd_q[1], 8'h3c);
        check("read nack", {7'h00, got_nack}, 8'h00);
        $display("test_acc_write done");
    endtask : test_acc_write

    task automatic test_mag_read();
        run_cmd(1'b1, 1'b1, 7'h08, 8'h00, 8'h00);
        check("mag bytes", 8'(rd_q.size()), 8'h02);
        check("mag byte 0", rd_q[0], 8'h48);
        check("mag byte 1", rd_q[1], 8'h43);
        check("mag last", {7'h00, got_last}, 8'h01);
        check("mag nack", {7'h00, got_nack}, 8'h00);
        $display("test_mag_read done");
    endtask : test_mag_read

    task automatic test_refuse();
        refuse <= 1'b1;
        run_cmd(1'b0, 1'b0, 7'h10, 8'hff, 8'hff);
        refuse <= 1'b0;
        check("refused nack", {7'h00, got_nack}, 8'h01);
        check("refused reg", i_dev.acc_mem[16], 8'h4a);
        $display("test_refuse done");
    endtask : test_refuse

    initial
    begin
        repeat (6) @(posedge ref_clk_i);
        check("reset oe", {6'h00, scl_oe_o, sda_oe_o}, 8'h00);
        srst_i <= 1'b0;
        test_acc_write();
        test_mag_read();
        test_refuse();
        give_verdict();
    end
endmodule : tb
